// ### hw/csc_clk_div.sv
// Purpose: half-period tick for the master serial clock
// Assumes: baud tick is a one-cycle pulse on the core clock
// Notes: counter rests at zero while not running
`timescale 1ns/1ps
`default_nettype none
module csc_clk_div import csc_pkg::*; (
  input wire logic clock, // core clock
  input wire logic rst, // async reset, high
  input wire logic run, // master frame in progress
  input wire logic [2:0] cks, // clock source code
  input wire logic baudTick, // baud generator pulse
  output logic tick // one pulse per half period
);

  logic [5:0] cnt_ff;
  logic tick_ff;
  logic [5:0] halfMask;
  logic rollover;

  // half period is 2^cks core cycles for the prescaled sources
  assign halfMask = 6'((7'h01 << cks) - 7'h01);
  assign rollover = (cnt_ff & halfMask) == halfMask;
  assign tick = tick_ff;

  // prescaler counter and tick flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_ff <= 6'h00;
      tick_ff <= 1'b0;
    end else if (!run) begin
      cnt_ff <= 6'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 6'h01;
      tick_ff <= (cks == CKS_BRG) ? baudTick : rollover;
    end
  end

endmodule
`default_nettype wire

// ### hw/csc_pkg.sv
// Purpose: shared constants, types and decoders of the serial channel config block
// Assumes: AXI4-Lite register map, 32-bit data, byte addresses
// Notes: every offset, every single-bit field position and the control byte reset value live here
package csc_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_MAIN = 8'h00;
  localparam logic [7:0] OFS_FMT = 8'h04;
  localparam logic [7:0] OFS_LEN = 8'h08;
  localparam logic [7:0] OFS_TX = 8'h0C;
  localparam logic [7:0] OFS_RX = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int MAIN_PWR = 7;
  localparam int MAIN_TXE = 6;
  localparam int MAIN_RXE = 5;
  localparam int MAIN_DIR = 4;
  localparam logic [7:0] MAIN_USED = 8'hF0;
  localparam int FMT_CKP = 4;
  localparam int FMT_DAP = 3;
  localparam logic [7:0] FMT_USED = 8'h1F;
  localparam int LEN_CL3 = 3;
  localparam logic [7:0] LEN_USED = 8'h0F;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int STAT_BUSY = 0;
  localparam logic [2:0] CKS_BRG = 3'h6;
  localparam logic [2:0] CKS_EXT = 3'h7;
  localparam logic [4:0] LEN_MIN = 5'h08;
  localparam logic [4:0] LEN_MAX = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {FR_IDLE, FR_RUN, FR_DRAIN} csc_frame_t;

  // length code to bit count: bit 3 set means the full 16
  function automatic logic [4:0] csc_bit_len(input logic [3:0] code);
    return code[LEN_CL3] ? LEN_MAX : LEN_MIN + {2'h0, code[2:0]};
  endfunction

  // ones in the low len bits of a data word
  function automatic logic [15:0] csc_len_mask(input logic [4:0] len);
    return 16'hFFFF >> (LEN_MAX - len);
  endfunction

endpackage

// ### hw/csc_shifter.sv
// Purpose: bit engine on the serial clock
// Assumes: txWord, bitLen and lsbFirst stay still while armed
// Notes: held in reset between frames, so no edge outside a frame matters
`timescale 1ns/1ps
`default_nettype none
module csc_shifter import csc_pkg::*; (
  input wire logic shiftClk, // rising edge captures
  input wire logic linkRst, // async reset, high between frames
  input wire logic lsbFirst, // 1 sends bit 0 first
  input wire logic [4:0] bitLen, // bits per frame
  input wire logic [15:0] txWord, // word to send
  input wire logic serialIn, // sampled line
  output logic serialOut, // current bit
  output logic [15:0] rxWord, // received word
  output logic done // level, last bit captured
);

  logic [4:0] capCnt_ff;
  logic [4:0] outIdx_ff;
  logic [15:0] rxShift_ff;
  logic done_ff;
  logic [4:0] txPos;
  logic [15:0] rxIns;

  assign txPos = lsbFirst ? outIdx_ff : 5'(bitLen - 5'h01 - outIdx_ff);
  assign serialOut = txWord[txPos[3:0]];
  assign rxIns = lsbFirst ? (rxShift_ff | (16'(serialIn) << capCnt_ff[3:0])) : {rxShift_ff[14:0], serialIn};
  assign rxWord = rxShift_ff;
  assign done = done_ff;

  // capture edge: sample and count
  always_ff @(posedge shiftClk or posedge linkRst) begin
    if (linkRst) begin
      capCnt_ff <= 5'h00;
      rxShift_ff <= 16'h0000;
      done_ff <= 1'b0;
    end else if (!done_ff) begin
      rxShift_ff <= rxIns;
      capCnt_ff <= capCnt_ff + 5'h01;
      done_ff <= capCnt_ff == 5'(bitLen - 5'h01);
    end
  end

  // shift edge: output follows the capture count, so the first bit is out before any edge
  always_ff @(negedge shiftClk or posedge linkRst) begin
    if (linkRst) begin
      outIdx_ff <= 5'h00;
    end else begin
      outIdx_ff <= capCnt_ff;
    end
  end

  property p_idxRange;
    @(posedge shiftClk) disable iff (linkRst) !done_ff |-> outIdx_ff < bitLen;
  endproperty
  a_idxRange: assert property (p_idxRange) else $error("output index beyond frame length");

  property p_rxAlign;
    @(posedge shiftClk) disable iff (linkRst) done_ff |-> (rxShift_ff & ~csc_len_mask(bitLen)) == 16'h0000;
  endproperty
  a_rxAlign: assert property (p_rxAlign) else $error("received bits above frame length");

endmodule
`default_nettype wire

// ### hw/csc_top.sv
// Purpose: clock format and length configuration of a clocked serial channel
// Assumes: AXI4-Lite slave on clock; linkClk is the sensed serial clock pin
// Notes: in master mode the pad loops sckOut back as linkClk
//
// Functional notes
// - the clock format register is 8 bits, byte writable and resets to zero.
// - the length register is 8 bits, whole-byte only, code in bits 3:0, resets to zero.
// - length codes 0 to 7 give 8 to 15 bits and any code with bit 3 set gives 16.
// - short words sit right-aligned at bit 0 whatever the shift direction.
// - unused upper transmit bits are ignored.
// - unused upper received bits read zero after each short transfer.
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module csc_top import csc_pkg::*; (
  input wire logic clock, // core clock
  input wire logic rst, // async reset, high
  input wire logic linkClk, // sensed serial clock pin
  input wire logic baudTick, // baud generator pulse
  input wire logic serialIn, // serial data in, link domain
  output logic serialOut, // serial data out
  output logic sckOut, // serial clock drive
  output logic sckOeN, // low while driving the clock
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready // read data ready
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] mainCtl_ff, fmtCtl_ff, lenCtl_ff;
  logic [15:0] txWord_ff, rxData_ff;
  logic [7:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  csc_frame_t state_ff, nxt_state;
  logic arm_ff, sck_ff, sckOeN_ff, doneMeta_ff, doneSync_ff;
  logic [5:0] edgeCnt_ff;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic power, enAny, locked, slave, lsbFirst, capFall, idleLvl;
  logic [2:0] cks;
  logic [4:0] bitLen;
  logic [15:0] lenMask, rxWord;
  logic doWrite, lane0, hitMain, hitFmt, hitLen, hitTx, mapped;
  logic wrMain, wrFmt, wrLen, wrTx, startFrame;
  logic edgesDone, frameEnd, divTick, divRun, linkDone, shiftClk, linkRst;
  logic rdHit;
  logic [31:0] rdMux;
  logic [7:0] wByte;

  assign power = mainCtl_ff[MAIN_PWR];
  assign enAny = mainCtl_ff[MAIN_TXE] | mainCtl_ff[MAIN_RXE];
  assign lsbFirst = mainCtl_ff[MAIN_DIR];
  assign locked = power & enAny;
  assign cks = fmtCtl_ff[2:0];
  assign slave = cks == CKS_EXT;
  // type picks idle level and capture edge
  assign capFall = fmtCtl_ff[FMT_CKP] ^ fmtCtl_ff[FMT_DAP];
  assign idleLvl = ~fmtCtl_ff[FMT_CKP];
  assign bitLen = csc_bit_len(lenCtl_ff[3:0]);
  assign lenMask = csc_len_mask(bitLen);

  // write strobes; one write is whole once both channels are held
  assign doWrite = ~awready_ff & ~wready_ff & ~bvalid_ff;
  assign lane0 = wStrb_ff[0];
  assign wByte = wData_ff[7:0];
  assign hitMain = awAddr_ff == OFS_MAIN;
  assign hitFmt = awAddr_ff == OFS_FMT;
  assign hitLen = awAddr_ff == OFS_LEN;
  assign hitTx = awAddr_ff == OFS_TX;
  assign mapped = hitMain | hitFmt | hitLen | hitTx | (awAddr_ff == OFS_RX) | (awAddr_ff == OFS_STAT);
  assign wrMain = doWrite & hitMain & lane0;
  assign wrFmt = doWrite & hitFmt & lane0 & ~locked;
  assign wrLen = doWrite & hitLen & lane0 & ~locked;
  assign wrTx = doWrite & hitTx & (state_ff == FR_IDLE);
  assign startFrame = wrTx & locked;

  // read decode; reserved bits come back zero
  assign rdHit = (araddr == OFS_MAIN) | (araddr == OFS_FMT) | (araddr == OFS_LEN) | (araddr == OFS_TX)
               | (araddr == OFS_RX) | (araddr == OFS_STAT);
  assign rdMux = (araddr == OFS_MAIN) ? {24'h000000, mainCtl_ff} :
                 (araddr == OFS_FMT) ? {24'h000000, fmtCtl_ff} :
                 (araddr == OFS_LEN) ? {24'h000000, lenCtl_ff} :
                 (araddr == OFS_TX) ? {16'h0000, txWord_ff} :
                 (araddr == OFS_RX) ? {16'h0000, rxData_ff} :
                 (araddr == OFS_STAT) ? 32'(state_ff != FR_IDLE) << STAT_BUSY : 32'h00000000;

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  // address and data are each held until the response is taken
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
    end else begin
      if (awvalid && awready_ff) begin
        awAddr_ff <= awaddr;
        awready_ff <= 1'b0;
      end
      if (wvalid && wready_ff) begin
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
        wready_ff <= 1'b0;
      end
      if (doWrite) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= mapped ? RESP_OKAY : RESP_DECERR;
      end
      if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rdMux;
      rresp_ff <= rdHit ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  // reset to zero
  // only the used bits of each control byte are kept
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mainCtl_ff <= RST_BYTE;
      fmtCtl_ff <= RST_BYTE;
      lenCtl_ff <= RST_BYTE;
      txWord_ff <= 16'h0000;
    end else begin
      if (wrMain) mainCtl_ff <= wByte & MAIN_USED;
      if (wrFmt) fmtCtl_ff <= wByte & FMT_USED;
      if (wrLen) lenCtl_ff <= wByte & LEN_USED;
      if (wrTx && lane0) txWord_ff[7:0] <= wByte;
      if (wrTx && wStrb_ff[1]) txWord_ff[15:8] <= wData_ff[15:8];
    end
  end

  // ------------------------------------------------------------
  // frame sequencing
  // ------------------------------------------------------------
  // master frame is two clock edges per bit
  assign edgesDone = edgeCnt_ff == {bitLen, 1'b0};
  assign frameEnd = (state_ff == FR_RUN) & doneSync_ff & (slave | edgesDone);
  assign divRun = (state_ff == FR_RUN) & ~slave & ~edgesDone;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      FR_IDLE: if (startFrame) nxt_state = FR_RUN;
      FR_RUN: if (!power || frameEnd) nxt_state = FR_DRAIN;
      FR_DRAIN: if (!doneSync_ff) nxt_state = FR_IDLE;
    endcase
  end

  // drain waits for the done level to fall so a stale one never ends the next frame
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= FR_IDLE;
      arm_ff <= 1'b0;
      rxData_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      arm_ff <= nxt_state == FR_RUN;
      if (frameEnd) rxData_ff <= rxWord & lenMask;
    end
  end

  // done level crosses from the link domain through two flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      doneMeta_ff <= 1'b0;
      doneSync_ff <= 1'b0;
    end else begin
      doneMeta_ff <= linkDone;
      doneSync_ff <= doneMeta_ff;
    end
  end

  // ------------------------------------------------------------
  // master serial clock
  // ------------------------------------------------------------
  csc_clk_div uDiv (
    .clock(clock),
    .rst(rst),
    .run(divRun),
    .cks(cks),
    .baudTick(baudTick),
    .tick(divTick)
  );

  // drive the pin only as master
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sck_ff <= 1'b1;
      sckOeN_ff <= 1'b1;
      edgeCnt_ff <= 6'h00;
    end else begin
      sckOeN_ff <= ~(power & ~slave);
      if (state_ff != FR_RUN) begin
        sck_ff <= idleLvl;
        edgeCnt_ff <= 6'h00;
      end else if (divTick && !edgesDone) begin
        sck_ff <= ~sck_ff;
        edgeCnt_ff <= edgeCnt_ff + 6'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // link domain
  // ------------------------------------------------------------
  // polarity xor folds all four types onto one capture edge; config is static in a frame
  assign shiftClk = linkClk ^ capFall;
  assign linkRst = rst | ~arm_ff;

  csc_shifter uShift (
    .shiftClk(shiftClk),
    .linkRst(linkRst),
    .lsbFirst(lsbFirst),
    .bitLen(bitLen),
    .txWord(txWord_ff),
    .serialIn(serialIn),
    .serialOut(serialOut),
    .rxWord(rxWord),
    .done(linkDone)
  );

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign sckOut = sck_ff;
  assign sckOeN = sckOeN_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_fmtWrite;
    doWrite && hitFmt && lane0 && !locked;
  endsequence
  property p_fmtWrite;
    s_fmtWrite |=> fmtCtl_ff == ($past(wByte) & FMT_USED);
  endproperty
  a_fmtWrite: assert property (p_fmtWrite) else $error("format write not stored");

  property p_fmtLock;
    locked && doWrite && hitFmt |=> $stable(fmtCtl_ff);
  endproperty
  a_fmtLock: assert property (p_fmtLock) else $error("format changed while locked");

  property p_lenUpper;
    $changed(lenCtl_ff) |-> (lenCtl_ff & ~LEN_USED) == 8'h00 && $past(doWrite && hitLen);
  endproperty
  a_lenUpper: assert property (p_lenUpper) else $error("length register upper bits set");

  property p_lenLock;
    locked && doWrite && hitLen |=> $stable(lenCtl_ff);
  endproperty
  a_lenLock: assert property (p_lenLock) else $error("length changed while locked");

  property p_edges;
    frameEnd && !slave |-> edgeCnt_ff == {bitLen, 1'b0};
  endproperty
  a_edges: assert property (p_edges) else $error("master frame edge count wrong");

  property p_rxZero;
    frameEnd |=> (rxData_ff & ~$past(lenMask)) == 16'h0000;
  endproperty
  a_rxZero: assert property (p_rxZero) else $error("received upper bits not zero");

  property p_fmtRead;
    arvalid && arready_ff && araddr == OFS_FMT |=> rvalid_ff && rdata_ff[7:5] == 3'h0;
  endproperty
  a_fmtRead: assert property (p_fmtRead) else $error("format reserved bits not zero");

  sequence s_masterTick;
    state_ff == FR_RUN && !slave && divTick && !edgesDone;
  endsequence
  property p_sckToggle;
    s_masterTick |=> sck_ff != $past(sck_ff) ##0 !sckOeN_ff || !power;
  endproperty
  a_sckToggle: assert property (p_sckToggle) else $error("master clock failed to toggle");

endmodule
`default_nettype wire

// ### tb/csc_peer.sv
// Purpose: serial device facing the channel on the clock and data lines
// Assumes: sck is the live serial clock and idles at the inverse of ckp
// Notes: makes its own clock only inside slave frames
`timescale 1ns/1ps
`default_nettype none
module csc_peer (
  input wire logic sck, // live serial clock
  input wire logic ckp, // clock polarity
  input wire logic dap, // data phase
  input wire logic lsbFirst, // bit order
  input wire logic [4:0] len, // bits per frame
  input wire logic [15:0] word, // word to send
  input wire logic arm, // rising edge readies a frame
  input wire logic slvGo, // rising edge starts the slave clock
  input wire logic sdo, // line from the channel
  output logic sdi, // line to the channel
  output logic slvClk, // clock made in slave frames
  output logic [15:0] got, // captured word
  output logic [4:0] cnt // bits captured
);
  logic on = 1'b0;

  // first bit stands before any edge
  always @(posedge arm) begin
    cnt = 5'h00;
    got = 16'h0000;
    slvClk = ~ckp;
    on = 1'b1;
    sdi = lsbFirst ? word[0] : word[len - 5'h01];
  end

  // slave clock runs only inside a frame, off the core clock phase
  always @(posedge slvGo) begin
    #7;
    repeat (2 * int'(len)) #15 slvClk = ~slvClk;
  end

  // capture on one edge, shift on the other; a released line flips so a stale bit never passes
  always @(sck) begin
    if (on && sck === (ckp == dap)) begin
      got = lsbFirst ? got | (16'(sdo) << cnt) : {got[14:0], sdo};
      cnt = cnt + 5'h01;
      if (cnt == len) begin
        on = 1'b0;
        sdi <= #8 ~sdi;
      end
    end else if (on && cnt != 5'h00) begin
      sdi = lsbFirst ? word[cnt] : word[len - 5'h01 - cnt];
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_csc_top.sv
// Purpose: self-checking bench of the clock format and length block
// Assumes: master frames loop sckOut back as the link clock
// Notes: each frame is configured with power off, then checked end to end
`timescale 1ns/1ps
`default_nettype none
module tb_csc_top import csc_pkg::*; ;
  logic clock, rst, baudTick, slave, slvGo, arm, pCkp, pDap, pLsb;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic serialIn, serialOut, sckOut, sckOeN, linkClk, slvClk;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [4:0] pLen, cnt;
  logic [15:0] pWord, got;
  logic prevSck;
  int error_cnt, samples_checked, cyc, tog, first, last;

  assign linkClk = slave ? slvClk : sckOut;

  csc_top dut (.clock(clock), .rst(rst), .linkClk(linkClk), .baudTick(baudTick), .serialIn(serialIn),
    .serialOut(serialOut), .sckOut(sckOut), .sckOeN(sckOeN), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  csc_peer peer (.sck(linkClk), .ckp(pCkp), .dap(pDap), .lsbFirst(pLsb), .len(pLen), .word(pWord),
    .arm(arm), .slvGo(slvGo), .sdo(serialOut), .sdi(serialIn), .slvClk(slvClk), .got(got), .cnt(cnt));

  // ----------------------------------------------------------
  // clock, baud pulse, toggle monitor and hang guard
  // ----------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // baud pulse every 5 cycles so its half period differs from every divider
  always @(posedge clock) begin
    cyc <= cyc + 1;
    baudTick <= (cyc % 5 == 4);
    prevSck <= sckOut;
    if (sckOut !== prevSck) begin
      tog = tog + 1;
      if (tog == 1) first = cyc;
      last = cyc;
    end
    if (cyc == 30000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ----------------------------------------------------------
  // bus tasks and checking
  // ----------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_regs();
    rd(OFS_FMT);
    chk("fmt reset", d, 32'h0);
    rd(OFS_LEN);
    chk("len reset", d, 32'h0);
    rd(8'h40);
    chk("unmapped resp", {30'h0, r}, {30'h0, RESP_DECERR});
    wr(OFS_FMT, 32'hFFFF_FFFF, 4'hF);
    rd(OFS_FMT);
    chk("fmt used bits", d, 32'h1F);
    wr(OFS_LEN, 32'hFF, 4'hF);
    rd(OFS_LEN);
    chk("len code bits", d, 32'h0F);
    wr(OFS_LEN, 32'h0, 4'hE);
    rd(OFS_LEN);
    chk("len without low lane", d, 32'h0F);
    // power and transmit on: both writes must be dropped
    wr(OFS_MAIN, 32'hC0, 4'hF);
    wr(OFS_FMT, 32'h0, 4'hF);
    rd(OFS_FMT);
    chk("fmt locked", d, 32'h1F);
    wr(OFS_LEN, 32'h0, 4'hF);
    rd(OFS_LEN);
    chk("len locked", d, 32'h0F);
    wr(OFS_MAIN, 32'h80, 4'hF);
    wr(OFS_FMT, 32'h15, 4'hF);
    rd(OFS_FMT);
    chk("fmt power only", d, 32'h15);
  endtask

  // one frame: configure, run, compare both directions and the clock
  task automatic xfer(input logic [7:0] fmt, input logic [3:0] code, input logic lsb, input logic [15:0] tx,
      input logic [15:0] pw);
    int bits;
    int half;
    logic [15:0] mask;
    bits = code[3] ? 16 : 8 + code[2:0];
    half = (fmt[2:0] == CKS_BRG) ? 5 : 1 << fmt[2:0];
    mask = 16'((32'h1 << bits) - 1);
    // software changes format and length only with power off
    wr(OFS_MAIN, 32'h0, 4'hF);
    wr(OFS_FMT, {24'h0, fmt}, 4'hF);
    wr(OFS_LEN, {28'h0, code}, 4'hF);
    wr(OFS_MAIN, {24'h0, 3'h7, lsb, 4'h0}, 4'hF);
    slave <= (fmt[2:0] == CKS_EXT);
    pCkp <= fmt[FMT_CKP];
    pDap <= fmt[FMT_DAP];
    pLsb <= lsb;
    pLen <= 5'(bits);
    pWord <= pw;
    @(posedge clock);
    arm <= 1'b1;
    @(posedge clock);
    arm <= 1'b0;
    if (!slave) chk("clock idle", {31'h0, sckOut}, {31'h0, ~fmt[FMT_CKP]});
    tog = 0;
    wr(OFS_TX, {16'hA5A5, tx}, 4'hF);
    chk("clock drive", {31'h0, sckOeN}, {31'h0, slave});
    if (slave) slvGo <= 1'b1;
    @(posedge clock);
    slvGo <= 1'b0;
    do begin
      rd(OFS_STAT);
    end while (d[STAT_BUSY] !== 1'b0);
    rd(OFS_RX);
    chk("rx word", d, {16'h0, pw & mask});
    chk("peer word", {16'h0, got}, {16'h0, tx & mask});
    chk("bit count", {27'h0, cnt}, 32'(bits));
    chk("toggles", tog, slave ? 0 : 2 * bits);
    if (!slave) chk("clock span", last - first, (2 * bits - 1) * half);
  endtask

  // write responses, power-off abort and a reset while idle with power off
  task automatic t_reset();
    wr(8'h40, 32'h0, 4'hF);
    chk("unmapped write resp", {30'h0, r}, {30'h0, RESP_DECERR});
    wr(OFS_MAIN, 32'h0, 4'hF);
    chk("mapped write resp", {30'h0, r}, {30'h0, RESP_OKAY});
    // slow master frame cut short by clearing power; the clock must park
    wr(OFS_FMT, 32'h05, 4'hF);
    wr(OFS_LEN, 32'h08, 4'hF);
    wr(OFS_MAIN, 32'hE0, 4'hF);
    wr(OFS_TX, 32'h1234, 4'hF);
    wr(OFS_MAIN, 32'h0, 4'hF);
    do begin
      rd(OFS_STAT);
    end while (d[STAT_BUSY] !== 1'b0);
    chk("abort clock idle", {31'h0, sckOut}, 32'h1);
    chk("abort clock released", {31'h0, sckOeN}, 32'h1);
    wr(OFS_FMT, 32'h1B, 4'hF);
    wr(OFS_LEN, 32'h05, 4'hF);
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    chk("reset clock level", {31'h0, sckOut}, 32'h1);
    chk("reset clock drive", {31'h0, sckOeN}, 32'h1);
    rd(OFS_FMT);
    chk("fmt after reset", d, 32'h0);
    chk("read resp", {30'h0, r}, {30'h0, RESP_OKAY});
    rd(OFS_LEN);
    chk("len after reset", d, 32'h0);
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, slave, slvGo, arm, pCkp, pDap, pLsb} = '0;
    {awaddr, araddr, wdata, wstrb, pLen, pWord, baudTick} = '0;
    {cyc, tog, first, last, error_cnt, samples_checked} = '0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    // every polarity/phase type, every clock source, boundary lengths
    xfer(8'h00, 4'h8, 1'b0, 16'hBEEF, 16'hFFFF);
    xfer(8'h09, 4'h0, 1'b1, 16'hFFA5, 16'h00C3);
    xfer(8'h12, 4'h7, 1'b0, 16'h8123, 16'h5A5A);
    xfer(8'h1B, 4'hF, 1'b1, 16'hC3A6, 16'h9009);
    xfer(8'h04, 4'h3, 1'b0, 16'hF70F, 16'h07FE);
    xfer(8'h0D, 4'h5, 1'b1, 16'hE5A1, 16'h1234);
    xfer(8'h1E, 4'h1, 1'b0, 16'hFE35, 16'h01AB);
    xfer(8'h17, 4'h6, 1'b1, 16'hC9B7, 16'h2C5D);
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
